/* File: sonar_echo_model.sv */
// Behavioural ranging module that answers each start pulse ending while no echo is pending with a timed echo.
module sonar_echo_model #(
  parameter int ECHO_DELAY = 10
) (
  // Clock and ranging pins.
  input wire logic hclk,
  input wire logic ping_start,
  output logic echo_out,
  // Echo length set by the bench, pulse figures seen by the model.
  input wire logic [15:0] echo_len,
  output int ping_width,
  output int ping_period,
  output int ping_total
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int last_rise = 0;
  bit was_high = 1'b0;
  event ping_end;

  //////////////////////////////////////////////////////////////////////////////
  // Measure the start pulse on the falling clock edge, where it is settled.
  always @(negedge hclk) begin
    cyc++;
    if (ping_start === 1'b1) begin
      if (!was_high) begin
        ping_period = cyc - last_rise;
        last_rise = cyc;
        ping_width = 0;
      end
      ping_width++;
    end else if (was_high) begin
      ping_total++;
      -> ping_end;
    end
    was_high = (ping_start === 1'b1);
  end

  //////////////////////////////////////////////////////////////////////////////
  // After each start pulse that ends with no echo pending, wait for the burst flight, then hold the return high.
  // The line is actively driven low between echoes, as the real module does.
  initial begin
    echo_out = 1'b0;
    ping_width = 0;
    ping_period = 0;
    ping_total = 0;
    forever begin
      @(ping_end);
      repeat (ECHO_DELAY) @(posedge hclk);
      echo_out <= 1'b1;
      repeat (echo_len) @(posedge hclk);
      echo_out <= 1'b0;
    end
  end
endmodule

/* File: sonar_pkg.sv */
// Constants, types and register map shared by the ultrasonic range timer.
package sonar_pkg;

  // Bus clock period and the least start-pulse time, in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int PING_MIN_NS = 10000;
  // A least time rounds up to whole clock cycles.
  localparam int PING_CYCLES = (PING_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter widths.
  localparam int TRIG_W = 12;
  localparam int FLIGHT_W = 22;
  localparam int SUP_W = 22;
  localparam logic [SUP_W-1:0] SUP_LAST = 22'h3FFFFF;
  localparam logic [TRIG_W-1:0] PING_COUNT = TRIG_W'(PING_CYCLES);

  // Register byte offsets, decoded on the low address bits.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_FLIGHT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;

  // Control register fields and reset value.
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_ECHO_BIT = 4;
  localparam int STAT_PING_BIT = 5;

  // Reset values of the data path.
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Measurement sequence, five states in a 3-bit code.
  typedef enum logic [2:0] {
    ST_PING_START,
    ST_PING_HOLD,
    ST_WAIT_RISE,
    ST_TIME_ECHO,
    ST_DONE
  } meas_state_e;

  // Captured address phase of one bus transfer.
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } ahb_req_s;

endpackage

/* File: ultrasonic_range_timer.sv */
// Ultrasonic range timer: start pulse, echo timing, supervision restart, bus slave.
//
// The AHB-Lite register port was chosen for this implementation.

//////////////////////////////////////////////////////////////////////////////
module ultrasonic_range_timer
  import sonar_pkg::*;
#(
  parameter logic [TRIG_W-1:0] PING_LIMIT = PING_COUNT,
  parameter logic [SUP_W-1:0] SUPERVISE_LAST = SUP_LAST
) (
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Ranging module pins.
  output logic ping_start,
  input wire logic echo_in
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  meas_state_e state_reg;
  meas_state_e state_next;
  logic [TRIG_W-1:0] trig_cnt_reg;
  logic [FLIGHT_W-1:0] flight_reg;
  logic [SUP_W-1:0] sup_cnt_reg;
  logic restart_n_reg;
  logic echo_prev_reg;
  logic ping_reg;
  logic run_reg;
  ahb_req_s req_reg;
  logic [31:0] rdata_reg;
  logic meas_rst_n;
  logic echo_rise;
  logic echo_fall;
  logic trig_done;
  logic sup_top;
  logic bus_accept;
  logic bus_write;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  ahb_req_s req_next;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection and decodes.

  // The edge compares the stored sample with the live input; inputs are synchronous.
  assign echo_rise = !echo_prev_reg && echo_in;
  assign echo_fall = echo_prev_reg && !echo_in;
  assign trig_done = (trig_cnt_reg == PING_LIMIT);
  assign sup_top = (sup_cnt_reg == SUPERVISE_LAST);

  // The restart is a flop output so the asynchronous clear never sees a glitch.
  assign meas_rst_n = hresetn && restart_n_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Supervision counter and restart pulse.

  // Free running; the restart flop goes low for the one cycle after the top.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_cnt_reg <= '0;
      restart_n_reg <= 1'b1;
    end else if (ce) begin
      sup_cnt_reg <= sup_top ? '0 : sup_cnt_reg + 1'b1;
      restart_n_reg <= !sup_top;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Return-line sample.

  // Kept out of the restart so an edge is never invented after a restart.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      echo_prev_reg <= 1'b0;
    end else if (ce) begin
      echo_prev_reg <= echo_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Measurement sequence.

  // Next state; state zero waits only while software has stopped ranging.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_PING_START: begin
        if (run_reg) begin
          state_next = ST_PING_HOLD;
        end
      end
      ST_PING_HOLD: begin
        if (trig_done) begin
          state_next = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (echo_rise) begin
          state_next = ST_TIME_ECHO;
        end
      end
      ST_TIME_ECHO: begin
        if (echo_fall) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
    endcase
  end

  // State, counters and the start pulse; the restart clears them at once.
  always_ff @(posedge hclk or negedge meas_rst_n) begin
    if (!meas_rst_n) begin
      state_reg <= ST_PING_START;
      trig_cnt_reg <= '0;
      flight_reg <= '0;
      ping_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      if (state_reg == ST_PING_START && run_reg) begin
        ping_reg <= 1'b1;
      end
      if (state_reg == ST_PING_HOLD) begin
        if (trig_done) begin
          ping_reg <= 1'b0;
        end else begin
          trig_cnt_reg <= trig_cnt_reg + 1'b1;
        end
      end
      if (state_reg == ST_TIME_ECHO && !echo_fall) begin
        flight_reg <= flight_reg + 1'b1;
      end
    end
  end

  assign ping_start = ping_reg;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave.

  // Only whole-word NONSEQ or SEQ transfers are taken; others pass as idle.
  assign bus_accept = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  assign bus_write = req_reg.valid && req_reg.write;

  // Address phase carried to the data phase.
  assign req_next.valid = bus_accept;
  assign req_next.write = hwrite;
  assign req_next.addr = haddr[ADDR_W-1:0];

  // Status word shows the sequence state, the done flag and both pins.
  assign status_word = {26'h0, ping_reg, echo_prev_reg, (state_reg == ST_DONE), state_reg};

  // Read selection; unmapped offsets read as zero.
  assign rd_mux = (haddr[ADDR_W-1:0] == OFS_FLIGHT) ? {10'h0, flight_reg} :
                  (haddr[ADDR_W-1:0] == OFS_CTRL) ? {31'h0, run_reg} :
                  (haddr[ADDR_W-1:0] == OFS_STATUS) ? status_word : 32'h0000_0000;

  // Zero wait states while enabled; a low enable stretches the transfer.
  assign hreadyout = ce;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_reg;

  // Read data is captured at the address edge, so reads leave state untouched.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
      rdata_reg <= RDATA_RESET;
    end else if (ce) begin
      req_reg <= req_next;
      if (bus_accept && !hwrite) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Control write lands in the data phase; the flight register ignores writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= CTRL_RUN_RESET;
    end else if (ce && bus_write && req_reg.addr == OFS_CTRL) begin
      run_reg <= hwdata[CTRL_RUN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Cycles the start pulse has been high, read only by the checks.
  logic [TRIG_W:0] ping_len_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ping_len_reg <= '0;
    end else begin
      ping_len_reg <= ping_reg ? ping_len_reg + 1'b1 : '0;
    end
  end

  // Checks share the bus clock; the measurement checks are disabled by a restart cycle, the supervision and bus checks by bus reset, the two reset checks never.
  default clocking cb @(posedge hclk);
  endclocking

  a_reset_state_zero: assert property (
    $rose(hresetn) |-> state_reg == ST_PING_START && flight_reg == '0)
    else $error("Sequence not in state zero after reset.");

  a_start_sets_ping: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_PING_START && run_reg && ce |=> state_reg == ST_PING_HOLD && ping_start)
    else $error("State zero did not raise the start pulse.");

  // A pulse cut short by the restart is not a finished start pulse, so it is left out.
  a_ping_min_width: assert property (
    disable iff (!meas_rst_n)
    $fell(ping_start) && meas_rst_n |-> ping_len_reg >= (TRIG_W + 1)'(PING_LIMIT) + 1'b1)
    else $error("Start pulse shorter than its minimum width.");

  a_hold_ends_ping: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_PING_HOLD && trig_done && ce |=> state_reg == ST_WAIT_RISE && !ping_start)
    else $error("Start pulse did not end at the width limit.");

  a_wait_on_rise: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_WAIT_RISE && ce |=> state_reg == ($past(echo_rise) ? ST_TIME_ECHO : ST_WAIT_RISE))
    else $error("Wait state mishandled the return edge.");

  a_flight_counts: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_TIME_ECHO && !echo_fall && ce |=> flight_reg == $past(flight_reg) + 1'b1)
    else $error("Flight time did not advance while the return was high.");

  a_fall_to_done: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_TIME_ECHO && echo_fall && ce |=> state_reg == ST_DONE && $stable(flight_reg))
    else $error("Falling return edge did not end the timing.");

  a_done_holds: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_DONE |=> state_reg == ST_DONE && $stable(flight_reg))
    else $error("Idle state did not hold the result.");

  a_sup_wrap: assert property (
    disable iff (!hresetn)
    sup_top && ce |=> sup_cnt_reg == '0 && !restart_n_reg ##1 restart_n_reg)
    else $error("Supervision counter did not wrap with a one-cycle restart.");

  a_restart_clears: assert property (
    disable iff (!hresetn)
    !restart_n_reg |-> state_reg == ST_PING_START && flight_reg == '0 && trig_cnt_reg == '0)
    else $error("Restart left the measurement state uncleared.");

  a_echo_sampled: assert property (
    disable iff (!hresetn)
    ce |=> echo_prev_reg == $past(echo_in))
    else $error("Return sample flop missed the input.");

  a_flight_readback: assert property (
    disable iff (!hresetn)
    bus_accept && !hwrite && haddr[ADDR_W-1:0] == OFS_FLIGHT |=> hrdata == {10'h0, $past(flight_reg)})
    else $error("Flight register read returned the wrong value.");

  a_sup_cleared: assert property (
    $rose(hresetn) |-> sup_cnt_reg == '0 && restart_n_reg)
    else $error("Bus reset left the supervision counter running.");

  a_ce_freezes: assert property (
    disable iff (!meas_rst_n)
    !ce |=> $stable(state_reg) && $stable(trig_cnt_reg) && $stable(flight_reg) && $stable(sup_cnt_reg))
    else $error("Low clock enable did not freeze the state.");

  a_idle_no_start: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_PING_START && !run_reg |=> state_reg == ST_PING_START && !ping_start)
    else $error("Stopped ranging still left state zero.");

  a_hold_keeps_ping: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_PING_HOLD |-> ping_start)
    else $error("Start pulse dropped during the hold state.");

  a_trig_counts: assert property (
    disable iff (!meas_rst_n)
    state_reg == ST_PING_HOLD && !trig_done && ce |=> trig_cnt_reg == $past(trig_cnt_reg) + 1'b1)
    else $error("Start-pulse width counter did not advance.");

  a_rdata_holds: assert property (
    disable iff (!hresetn)
    !(bus_accept && !hwrite) |=> $stable(hrdata))
    else $error("Read data changed without an accepted read.");

  c_full_measure: cover property (
    disable iff (!meas_rst_n)
    state_reg == ST_TIME_ECHO ##1 state_reg == ST_DONE);

  c_restart_in_wait: cover property (
    disable iff (!hresetn)
    state_reg == ST_WAIT_RISE ##1 !restart_n_reg);

  c_ctrl_stop: cover property (
    disable iff (!hresetn)
    bus_write && req_reg.addr == OFS_CTRL && !hwdata[CTRL_RUN_BIT]);

  c_flight_read: cover property (
    disable iff (!hresetn)
    bus_accept && !hwrite && haddr[ADDR_W-1:0] == OFS_FLIGHT && flight_reg != '0);

  c_run_resume: cover property (
    disable iff (!hresetn)
    state_reg == ST_PING_START && !run_reg ##1 run_reg);

endmodule

/* File: ultrasonic_range_timer_tb_top.sv */
// Self-checking bench for the ultrasonic range timer over AHB-Lite.
module ultrasonic_range_timer_tb_top import sonar_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run brief; every timing expectation derives from these.
  localparam logic [TRIG_W-1:0] PL = 12'd20;
  localparam logic [SUP_W-1:0] SL = 22'd600;
  localparam int E1 = 30;
  localparam int E2 = 100;
  localparam int TIMEOUT = 20000;
  logic hclk = 1'b0;
  logic hresetn, ce, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, ping_start, echo_in;
  logic [15:0] echo_len;
  int ping_width, ping_period, ping_total;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  ultrasonic_range_timer #(.PING_LIMIT(PL), .SUPERVISE_LAST(SL)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ping_start(ping_start), .echo_in(echo_in));

  sonar_echo_model model (.hclk(hclk), .ping_start(ping_start), .echo_out(echo_in), .echo_len(echo_len),
    .ping_width(ping_width), .ping_period(ping_period), .ping_total(ping_total));

  //////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so that a hung wait still reaches the report.
  always #20 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      failures++;
      $display("[ERR] timeout expected done seen hang");
      test_done();
    end
  end

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single AHB-Lite word transfer; entered just after a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask

  // Poll the status word until the measurement has finished.
  task automatic poll_done();
    logic [31:0] s;
    do xfer(1'b0, OFS_STATUS, 32'h0, s); while (s[STAT_DONE_BIT] !== 1'b1);
    chk("state", 32'(ST_DONE), {29'h0, s[2:0]});
  endtask

  // Print the counts and the verdict, then stop.
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: two measurements, restart period, run control, stall, reset.
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    echo_len = 16'(E1);
    repeat (20) @(posedge hclk);
    chk("ping in reset", 32'h0, 32'(ping_start));
    hresetn <= 1'b1;
    poll_done();
    chk("ping width", 32'(PL) + 32'h1, ping_width);
    xfer(1'b0, OFS_FLIGHT, 32'h0, rd);
    chk("flight", 32'(E1 - 1), rd);
    xfer(1'b1, OFS_FLIGHT, 32'hFFFFFFFF, rd);
    xfer(1'b0, OFS_FLIGHT, 32'h0, rd);
    chk("flight again", 32'(E1 - 1), rd);
    xfer(1'b0, 8'h0C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    echo_len <= 16'(E2);
    while (ping_total < 2) @(posedge hclk);
    // The first ping follows bus reset at once; later ones also wait out the restart release edge.
    chk("restart period", 32'(SL) + 32'h2, ping_period);
    xfer(1'b0, OFS_FLIGHT, 32'h0, rd);
    chk("flight cleared", 32'h0, rd);
    poll_done();
    xfer(1'b0, OFS_FLIGHT, 32'h0, rd);
    chk("flight long", 32'(E2 - 1), rd);
    // Software scale in ten-thousandths of a centimetre, truncated.
    chk("distance", 32'((E2 - 1) * 34 / 10), 32'($rtoi(real'(rd) * 34.0 / 100000.0 * 1.0e4)));
    xfer(1'b1, OFS_CTRL, 32'h0, rd);
    xfer(1'b0, OFS_CTRL, 32'h0, rd);
    chk("run off", 32'h0, rd);
    repeat (int'(SL) + 100) @(posedge hclk);
    chk("no ping when off", 32'h2, ping_total);
    xfer(1'b1, OFS_CTRL, 32'h1, rd);
    while (ping_total < 3) @(posedge hclk);
    chk("ping width on", 32'(PL) + 32'h1, ping_width);
    ce <= 1'b0;
    @(posedge hclk);
    chk("stall", 32'h0, 32'(hreadyout));
    ce <= 1'b1;
    // Two edges pass so the frozen cycle is checked before the reset disables the checks.
    repeat (2) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk("ping after reset", 32'h0, 32'(ping_start));
    hresetn <= 1'b1;
    poll_done();
    xfer(1'b0, OFS_FLIGHT, 32'h0, rd);
    chk("flight after reset", 32'(E2 - 1), rd);
    test_done();
  end
endmodule
